// ### dhs_pkg.sv
// package: register map, field positions, reset values, timing and states of the homing sequencer
package dhs_pkg;
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CMD = 8'h00;
	localparam logic [AXI_AW-1:0] REG_CFG = 8'h04;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [AXI_AW-1:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 8'h10;
	localparam logic [AXI_AW-1:0] REG_RAPID = 8'h14;
	localparam logic [AXI_AW-1:0] REG_APPROACH = 8'h18;
	localparam logic [AXI_AW-1:0] REG_SHIFT = 8'h1c;
	localparam logic [AXI_AW-1:0] REG_MASK = 8'h20;
	localparam logic [AXI_AW-1:0] REG_SPACING = 8'h24;
	localparam logic [AXI_AW-1:0] REG_OFFSET = 8'h28;
	localparam logic [AXI_AW-1:0] REG_DECEL = 8'h2c;
	localparam logic [AXI_AW-1:0] REG_TRAVERSE = 8'h30;
	localparam logic [AXI_AW-1:0] REG_GRID_AMT = 8'h34;
	localparam logic [AXI_AW-1:0] REG_MACH_POS = 8'h38;
	localparam logic [AXI_AW-1:0] REG_REF_POS = 8'h3c;
	localparam int CMD_HOME_BIT = 0;
	localparam int CMD_MOVE_BIT = 1;
	localparam int CFG_DIR_BIT = 0;
	localparam int CFG_HS_BIT = 1;
	localparam int CFG_NOREF_BIT = 2;
	localparam int CFG_GDISP_BIT = 6;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [6:0] CFG_RST = 7'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [31:0] RAPID_RST = 32'h0000_0100;
	localparam logic [31:0] APPROACH_RST = 32'h0000_0004;
	localparam logic [31:0] SHIFT_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	localparam logic [31:0] SPACING_RST = 32'h0000_0000;
	localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
	localparam logic [31:0] DECEL_RST = 32'h0000_0010;
	localparam logic [31:0] TRAVERSE_RST = 32'h0000_0200;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 5;
	localparam int DOG_DEBOUNCE_NS = 1000;
	localparam int DOG_DEB_CYC = (DOG_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_W = $clog2(DOG_DEB_CYC + 1);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RAPID = 3'h1,
		ST_DECEL = 3'h3,
		ST_CREEP = 3'h2,
		ST_MASK = 3'h6,
		ST_SEEK = 3'h7,
		ST_SHIFT = 3'h5,
		ST_HIGH = 3'h4
	} dhs_state_t;
endpackage

// ### dhs_filt_if.sv
// interface: conditioned dog level and index pulse from the input filter
`timescale 1ns/1ps
`default_nettype none
interface dhs_filt_if;
	logic dogLevel;
	logic zPulse;
	modport prod (output dogLevel, output zPulse);
	modport cons (input dogLevel, input zPulse);
endinterface
`default_nettype wire

// ### dhs_input_filter.sv
// input conditioning: synchronisers, dog debounce, index edge pulse
`timescale 1ns/1ps
`default_nettype none
module dhs_input_filter
	import dhs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [1:0] rawIn,
	dhs_filt_if.prod filt
);
	logic [1:0] syncA_reg;
	logic [1:0] syncB_reg;
	logic zPrev_reg;
	logic dogStable_reg;
	logic [DEB_W-1:0] debCnt_reg;

	// bit 0 dog, bit 1 index; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					syncA_reg[i] <= 1'b0;
					syncB_reg[i] <= 1'b0;
				end else begin
					syncA_reg[i] <= rawIn[i];
					syncB_reg[i] <= syncA_reg[i];
				end
			end
		end
	endgenerate

	// dog switch bounces; index is a clean encoder signal, so only synced
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			debCnt_reg <= '0;
			dogStable_reg <= 1'b0;
		end else if (syncB_reg[0] == dogStable_reg) begin
			debCnt_reg <= '0;
		end else if (debCnt_reg == DEB_W'(DOG_DEB_CYC - 1)) begin
			debCnt_reg <= '0;
			dogStable_reg <= syncB_reg[0];
		end else begin
			debCnt_reg <= debCnt_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			zPrev_reg <= 1'b0;
		end else begin
			zPrev_reg <= syncB_reg[1];
		end
	end

	assign filt.dogLevel = dogStable_reg;
	assign filt.zPulse = syncB_reg[1] & ~zPrev_reg;
endmodule
`default_nettype wire

// ### dhs_homing.sv
// top: dog-type and high-speed homing sequencer with AXI4-Lite registers
// Notes on behaviour
// - dog homing starts at the homing rapid rate in the return direction
// - dog seen during rapid: ramp down by the decel step, then step to approach speed and creep
// - stop on first grid point after dog release; that is the electrical zero
// - first homing is dog-type; later ones dog or high-speed per config
// - high-speed homing goes straight to stored reference at traverse rate
// - non-homing motion before first homing is refused and flags an error
// - each encoder index pulse marks a grid point
// - extra grid points at a configurable spacing between index pulses
// - nonzero mask ignores grid points for that distance after dog release
// - grid amount measured from dog release, or from mask end when masked and grid display select is 1
// - reference is electrical zero shifted by shift amount in return direction
// - return direction 0 is positive, 1 is negative
// - no-reference 0 enables homing; 1 runs without homing needed
// - after homing machine position equals offset at the reference
// - approach speed starts and stops as a step, no ramp
// - same rapid rate for manual and automatic dog homing
// - grid display select 0 includes mask distance, 1 excludes it
`timescale 1ns/1ps
`default_nettype none
module dhs_homing
	import dhs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dogIn,
	input wire logic encZIn,
	input wire logic signed [31:0] posIn,
	output logic signed [31:0] velCmd,
	output logic moveGrant,
	output logic homed,
	output logic irq
);
	dhs_filt_if filt ();
	dhs_input_filter u_filter (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.rawIn({encZIn, dogIn}),
		.filt(filt.prod)
	);

	dhs_state_t state_reg;
	logic [6:0] cfg_reg;
	logic [IRQ_W-1:0] irqStat_reg;
	logic [IRQ_W-1:0] irqMask_reg;
	logic [31:0] rapid_reg;
	logic [31:0] approach_reg;
	logic [31:0] shift_reg;
	logic [31:0] mask_reg;
	logic [31:0] spacing_reg;
	logic [31:0] offset_reg;
	logic [31:0] decel_reg;
	logic [31:0] traverse_reg;
	logic [31:0] gridAmt_reg;
	logic signed [31:0] machPos_reg;
	logic signed [31:0] refPos_reg;
	logic signed [31:0] releasePos_reg;
	logic signed [31:0] maskEndPos_reg;
	logic signed [31:0] zeroPos_reg;
	logic signed [31:0] posPrev_reg;
	logic signed [31:0] gridAcc_reg;
	logic signed [31:0] gridAcc_next;
	logic gridHit_reg;
	logic firstDone_reg;
	logic homeCmd;
	logic moveCmd;
	logic doneEvt;
	logic errEvt;
	logic [AXI_AW-1:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic awHave_reg;
	logic wHave_reg;
	logic wrFire;
	logic wrHit;
	logic [31:0] rdMux;
	logic rdHit;
	logic dirNeg;
	logic signed [31:0] velMag;

	assign dirNeg = cfg_reg[CFG_DIR_BIT];

	function automatic logic [31:0] absDiff(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [31:0] d;
		d = a - b;
		absDiff = d[31] ? 32'(-d) : d;
	endfunction

	function automatic logic signed [31:0] signedVel(input logic [31:0] mag, input logic neg);
		signedVel = neg ? 32'(-$signed(mag)) : $signed(mag);
	endfunction

	// write channel: address and data accepted in either order
	assign wrFire = awHave_reg && wHave_reg && !s_axi_bvalid;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !awHave_reg && !s_axi_awready;
			s_axi_wready <= !wHave_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
				awHave_reg <= 1'b0;
				wHave_reg <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case ({awAddr_reg[AXI_AW-1:2], 2'b00})
			REG_CMD, REG_CFG, REG_IRQ_STAT, REG_IRQ_MASK, REG_RAPID, REG_APPROACH,
			REG_SHIFT, REG_MASK, REG_SPACING, REG_OFFSET, REG_DECEL,
			REG_TRAVERSE: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	assign homeCmd = wrFire && awAddr_reg == REG_CMD && wData_reg[CMD_HOME_BIT];
	assign moveCmd = wrFire && awAddr_reg == REG_CMD && wData_reg[CMD_MOVE_BIT];

	// configuration registers; byte strobes are not honoured, full words only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg <= CFG_RST;
			irqMask_reg <= IRQ_MASK_RST;
			rapid_reg <= RAPID_RST;
			approach_reg <= APPROACH_RST;
			shift_reg <= SHIFT_RST;
			mask_reg <= MASK_RST;
			spacing_reg <= SPACING_RST;
			offset_reg <= OFFSET_RST;
			decel_reg <= DECEL_RST;
			traverse_reg <= TRAVERSE_RST;
		end else if (wrFire) begin
			unique case (awAddr_reg)
				REG_CFG: cfg_reg <= wData_reg[6:0];
				REG_IRQ_MASK: irqMask_reg <= wData_reg[IRQ_W-1:0];
				REG_RAPID: rapid_reg <= wData_reg;
				REG_APPROACH: approach_reg <= wData_reg;
				REG_SHIFT: shift_reg <= wData_reg;
				REG_MASK: mask_reg <= wData_reg;
				REG_SPACING: spacing_reg <= wData_reg;
				REG_OFFSET: offset_reg <= wData_reg;
				REG_DECEL: decel_reg <= wData_reg;
				REG_TRAVERSE: traverse_reg <= wData_reg;
				default: ;
			endcase
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqStat_reg <= '0;
			irq <= 1'b0;
		end else begin
			for (int b = 0; b < IRQ_W; b++) begin
				if ((b == IRQ_DONE_BIT && doneEvt) || (b == IRQ_ERR_BIT && errEvt)) begin
					irqStat_reg[b] <= 1'b1;
				end else if (wrFire && awAddr_reg == REG_IRQ_STAT && wData_reg[b]) begin
					irqStat_reg[b] <= 1'b0;
				end
			end
			irq <= |(irqStat_reg & irqMask_reg);
		end
	end

	// read channel
	always_comb begin
		rdHit = 1'b1;
		unique case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
			REG_CMD: rdMux = 32'h0000_0000;
			REG_CFG: rdMux = {25'h0, cfg_reg};
			REG_STATUS: rdMux = {26'h0, state_reg, firstDone_reg, homed, filt.dogLevel};
			REG_IRQ_STAT: rdMux = {30'h0, irqStat_reg};
			REG_IRQ_MASK: rdMux = {30'h0, irqMask_reg};
			REG_RAPID: rdMux = rapid_reg;
			REG_APPROACH: rdMux = approach_reg;
			REG_SHIFT: rdMux = shift_reg;
			REG_MASK: rdMux = mask_reg;
			REG_SPACING: rdMux = spacing_reg;
			REG_OFFSET: rdMux = offset_reg;
			REG_DECEL: rdMux = decel_reg;
			REG_TRAVERSE: rdMux = traverse_reg;
			REG_GRID_AMT: rdMux = gridAmt_reg;
			REG_MACH_POS: rdMux = machPos_reg;
			REG_REF_POS: rdMux = refPos_reg;
			default: begin
				rdMux = 32'h0000_0000;
				rdHit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// grid generator: index resets the phase, spacing adds points in between;
	// assumes the axis moves less than one spacing per clock
	always_comb begin
		gridAcc_next = gridAcc_reg + (posIn - posPrev_reg);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			posPrev_reg <= '0;
			gridAcc_reg <= '0;
			gridHit_reg <= 1'b0;
		end else begin
			posPrev_reg <= posIn;
			gridHit_reg <= 1'b0;
			if (filt.zPulse) begin
				gridAcc_reg <= '0;
				gridHit_reg <= 1'b1;
			end else if (spacing_reg != 32'h0 && gridAcc_next >= $signed(spacing_reg)) begin
				gridAcc_reg <= gridAcc_next - $signed(spacing_reg);
				gridHit_reg <= 1'b1;
			end else if (spacing_reg != 32'h0 && gridAcc_next < 0) begin
				gridAcc_reg <= gridAcc_next + $signed(spacing_reg);
				gridHit_reg <= 1'b1;
			end else begin
				gridAcc_reg <= gridAcc_next;
			end
		end
	end

	// command acceptance
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			moveGrant <= 1'b0;
			errEvt <= 1'b0;
		end else begin
			moveGrant <= moveCmd && state_reg == ST_IDLE && (homed || cfg_reg[CFG_NOREF_BIT]);
			errEvt <= moveCmd && !homed && !cfg_reg[CFG_NOREF_BIT];
		end
	end

	// sequencer and velocity command
	assign velMag = velCmd[31] ? 32'(-velCmd) : velCmd;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			velCmd <= '0;
			releasePos_reg <= '0;
			maskEndPos_reg <= '0;
			zeroPos_reg <= '0;
			refPos_reg <= '0;
			gridAmt_reg <= '0;
			firstDone_reg <= 1'b0;
			homed <= 1'b0;
			doneEvt <= 1'b0;
		end else begin
			doneEvt <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (homeCmd && cfg_reg[CFG_NOREF_BIT]) begin
						homed <= 1'b1;
					end else if (homeCmd && firstDone_reg && cfg_reg[CFG_HS_BIT]) begin
						state_reg <= ST_HIGH;
						velCmd <= signedVel(traverse_reg, posIn > refPos_reg);
					end else if (homeCmd) begin
						state_reg <= ST_RAPID;
						velCmd <= signedVel(rapid_reg, dirNeg);
					end
				end
				ST_RAPID: begin
					if (filt.dogLevel) begin
						state_reg <= ST_DECEL;
					end
				end
				ST_DECEL: begin
					if (velMag <= $signed(decel_reg)) begin
						state_reg <= ST_CREEP;
						velCmd <= signedVel(approach_reg, dirNeg);
					end else begin
						velCmd <= signedVel(32'(velMag - $signed(decel_reg)), dirNeg);
					end
				end
				ST_CREEP: begin
					if (!filt.dogLevel) begin
						releasePos_reg <= posIn;
						maskEndPos_reg <= posIn;
						state_reg <= (mask_reg != 32'h0) ? ST_MASK : ST_SEEK;
					end
				end
				ST_MASK: begin
					// acts like a longer dog: grid points are ignored here
					if (absDiff(posIn, releasePos_reg) >= mask_reg) begin
						maskEndPos_reg <= posIn;
						state_reg <= ST_SEEK;
					end
				end
				ST_SEEK: begin
					if (gridHit_reg) begin
						zeroPos_reg <= posIn;
						gridAmt_reg <= cfg_reg[CFG_GDISP_BIT] ? absDiff(posIn, maskEndPos_reg)
							: absDiff(posIn, releasePos_reg);
						if (shift_reg == 32'h0) begin
							velCmd <= '0;
							refPos_reg <= posIn;
							state_reg <= ST_IDLE;
							homed <= 1'b1;
							firstDone_reg <= 1'b1;
							doneEvt <= 1'b1;
						end else begin
							state_reg <= ST_SHIFT;
						end
					end
				end
				ST_SHIFT: begin
					// shift only continues the return direction at approach speed
					if (absDiff(posIn, zeroPos_reg) >= shift_reg) begin
						velCmd <= '0;
						refPos_reg <= posIn;
						state_reg <= ST_IDLE;
						homed <= 1'b1;
						firstDone_reg <= 1'b1;
						doneEvt <= 1'b1;
					end
				end
				ST_HIGH: begin
					if (absDiff(posIn, refPos_reg) <= traverse_reg) begin
						velCmd <= '0;
						state_reg <= ST_IDLE;
						doneEvt <= 1'b1;
					end
				end
			endcase
		end
	end

	// machine coordinate: offset appears at the reference once homed
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			machPos_reg <= '0;
		end else begin
			machPos_reg <= posIn - refPos_reg + $signed(offset_reg);
		end
	end
endmodule
`default_nettype wire

// ### dhs_homing_chk.sv
// checker: bus handshake and homing output properties bound to the sequencer top
`timescale 1ns/1ps
`default_nettype none
module dhs_homing_chk
	import dhs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [31:0] velCmd,
	input wire logic moveGrant,
	input wire logic homed
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before rready");
	rvalid_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
		else $error("read answer without an address handshake");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address offered while read data pending");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held for two cycles");
	homed_halt_a: assert property ($rose(homed) |-> velCmd == 32'sd0)
		else $error("homed raised while axis still commanded");
	homed_sticky_a: assert property (homed |=> homed)
		else $error("homed dropped without reset");
	grant_pulse_a: assert property (moveGrant |=> !moveGrant)
		else $error("move grant longer than one cycle");
endmodule
bind dhs_homing dhs_homing_chk i_chk(.ref_clk, .rst_b, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.velCmd, .moveGrant, .homed);
`default_nettype wire

// ### dhs_axis_model.sv
// axis model: integrates commanded velocity, near-point dog switch and index pulse
`timescale 1ns/1ps
`default_nettype none
module dhs_axis_model #(
	parameter int DOG_LO = 2000,
	parameter int DOG_HI = 6000,
	parameter int PITCH = 4096
) (
	input wire logic ref_clk,
	input wire logic signed [31:0] velCmd,
	output logic signed [31:0] posOut,
	output logic dogOut,
	output logic zOut
);
	logic signed [31:0] nextPos;
	logic [1:0] zCnt = 2'h0;
	initial posOut = 32'sd0;
	assign nextPos = posOut + velCmd;
	// switch is a plain level: no release state to model
	assign dogOut = posOut >= DOG_LO && posOut <= DOG_HI;
	// pulse stretched to three cycles so a two-flop synchroniser always sees it
	assign zOut = zCnt != 2'h0;
	always @(posedge ref_clk) begin
		posOut <= nextPos;
		if (nextPos / PITCH != posOut / PITCH) begin
			zCnt <= 2'h3;
		end else if (zCnt != 2'h0) begin
			zCnt <= zCnt - 2'h1;
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// testbench: register checks and dog homing scenarios against the axis model
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import dhs_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [31:0] v;} dhs_row_t;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic moveGrant, homed, irq, dogIn, encZIn;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic signed [31:0] posIn, velCmd, refPos;
	int errTotal = 0, testsRun = 0, cyc = 0, grants = 0;
	dhs_row_t rows [13] = '{'{REG_CFG, {25'h0, CFG_RST}}, '{REG_IRQ_MASK, {30'h0, IRQ_MASK_RST}},
		'{REG_RAPID, RAPID_RST}, '{REG_APPROACH, APPROACH_RST}, '{REG_SHIFT, SHIFT_RST},
		'{REG_MASK, MASK_RST}, '{REG_SPACING, SPACING_RST}, '{REG_OFFSET, OFFSET_RST},
		'{REG_DECEL, DECEL_RST}, '{REG_TRAVERSE, TRAVERSE_RST}, '{REG_STATUS, 32'h0},
		'{REG_CMD, 32'h0}, '{REG_IRQ_STAT, 32'h0}};
	always #2.5 ref_clk = ~ref_clk;
	dhs_homing i_dut(.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .dogIn, .encZIn, .posIn, .velCmd, .moveGrant, .homed, .irq);
	dhs_axis_model i_axis(.ref_clk, .velCmd, .posOut(posIn), .dogOut(dogIn), .zOut(encZIn));
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// generous ceiling: a full dog homing needs about one thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (moveGrant === 1'b1) begin
			grants++;
		end
		if (cyc == 30000) begin
			errTotal++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
			end
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
			end
		end while (!s_axi_rvalid);
		rsp = s_axi_rresp;
		rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulseReset;
		rst_b <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
	endtask
	initial begin
		pulseReset();
		foreach (rows[i]) begin
			rdr(rows[i].a);
			chk("reset value", rows[i].v, rd);
		end
		rdr(8'h40);
		chk("unmapped rresp", RESP_SLVERR, rsp);
		chk("unmapped rdata", 32'h0, rd);
		wr(8'h40, 32'h1);
		chk("unmapped bresp", RESP_SLVERR, rsp);
		// motion before any homing must be refused
		wr(REG_IRQ_MASK, 32'h3);
		wr(REG_CMD, 32'h2);
		rdr(REG_IRQ_STAT);
		chk("error flag", 32'h2, rd);
		chk("irq raised", 32'h1, irq);
		chk("no grant", 32'h0, grants);
		wr(REG_IRQ_STAT, 32'h2);
		rdr(REG_IRQ_STAT);
		chk("flag cleared", 32'h0, rd);
		chk("irq cleared", 32'h0, irq);
		// dog homing in the positive direction
		wr(REG_RAPID, 32'h10);
		wr(REG_CMD, 32'h1);
		chk("rapid velocity", 32'h10, velCmd);
		for (int n = 0; n < 4000 && velCmd !== APPROACH_RST; n++) @(posedge ref_clk);
		chk("approach velocity", APPROACH_RST, velCmd);
		for (int n = 0; n < 4000 && homed !== 1'b1; n++) @(posedge ref_clk);
		chk("homed", 32'h1, homed);
		chk("stopped", 32'h0, velCmd);
		chk("stop at index", 32'h1, posIn >= 32'sd8192 && posIn < 32'sd8256);
		rdr(REG_REF_POS);
		refPos = rd;
		chk("ref pos", 32'h1, refPos >= 32'sd8192 && refPos <= posIn);
		rdr(REG_GRID_AMT);
		chk("grid amount", 32'h1, rd > 32'h0 && rd < 32'h1000);
		rdr(REG_IRQ_STAT);
		chk("done flag", 32'h1, rd);
		wr(REG_OFFSET, 32'h100);
		rdr(REG_MACH_POS);
		chk("machine pos", posIn - refPos + 32'sh100, rd);
		wr(REG_CMD, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk("grant after homing", 32'h1, grants);
		// second homing selects the high-speed method
		wr(REG_IRQ_STAT, 32'h3);
		wr(REG_CFG, 32'h2);
		wr(REG_CMD, 32'h1);
		repeat (4) @(posedge ref_clk);
		rdr(REG_IRQ_STAT);
		chk("fast done", 32'h1, rd);
		rdr(REG_STATUS);
		chk("fast idle", 32'h0, rd[5:3]);
		// mid-run reset, then homing in the negative direction
		pulseReset();
		@(posedge ref_clk);
		chk("homed cleared", 32'h0, homed);
		// slow rapid so the dog stays on longer than the debounce time
		wr(REG_RAPID, 32'h10);
		wr(REG_SPACING, 32'h400);
		wr(REG_MASK, 32'h200);
		wr(REG_CFG, 32'h41);
		wr(REG_CMD, 32'h1);
		chk("negative rapid", 32'hffff_fff0, velCmd);
		// masked return over spacing grid points, amount shown without the mask
		for (int n = 0; n < 4000 && homed !== 1'b1; n++) @(posedge ref_clk);
		chk("masked homed", 32'h1, homed);
		rdr(REG_GRID_AMT);
		chk("masked grid amount", 32'h1, rd < 32'h410);
		// reset stops the axis; no-reference axis moves without homing
		pulseReset();
		wr(REG_CFG, 32'h4);
		wr(REG_CMD, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk("noref grant", 32'h2, grants);
		summarize();
	end
endmodule
`default_nettype wire
